// file: pkg/chg_defines.svh
// register map, field positions, defaults and timing figures of the charger control block
`ifndef CHG_DEFINES_SVH
`define CHG_DEFINES_SVH

`define CHG_ADDR_CTRL      8'h00
`define CHG_ADDR_LIMIT     8'h04
`define CHG_ADDR_CHARGE    8'h08
`define CHG_ADDR_SAFETY    8'h0c
`define CHG_ADDR_STATUS    8'h10

`define CHG_CTRL_KICK      0
`define CHG_CTRL_RESET     1
`define CHG_CTRL_HIZ       2
`define CHG_CTRL_CE        3
`define CHG_CTRL_TE        4
`define CHG_CTRL_DETEN     5

`define CHG_VREG_DEF_MV    13'h0e10
`define CHG_VREG_HV_MV     13'h1068
`define CHG_ICHG_DEF_MA    12'h03e8
`define CHG_WARM_DROP_MV   13'h008c

`define CHG_ILIM_100       2'h0
`define CHG_ILIM_500       2'h1
`define CHG_ILIM_1500      2'h2

`define CHG_PORT_SDP       2'h0
`define CHG_PORT_CDP       2'h1
`define CHG_PORT_DCP       2'h2

`define CHG_FAULT_NONE     3'h0
`define CHG_FAULT_SAFETY   3'h1

`define CHG_RESP_OKAY      2'h0
`define CHG_RESP_SLVERR    2'h2

`define CHG_CLK_NS         4
`define CHG_TICK_NS        1000000
`define CHG_PULSE_NS       128000
`define CHG_WDOG_MS        30000
`define CHG_CONN_MS        500
`define CHG_MS_PER_MIN     60000
`define CHG_SAFE_MIN0      2
`define CHG_SAFE_MIN1      360
`define CHG_SAFE_MIN2      540
`define CHG_SAFE_MIN3      720

`endif

// file: pkg/chg_pkg.sv
// types shared by the charger control block
package chg_pkg;

	typedef enum logic [3:0] {
		cs_idle  = 4'b0001,
		cs_run   = 4'b0010,
		cs_done  = 4'b0100,
		cs_fault = 4'b1000
	} chg_state_t;

	typedef enum logic [2:0] {
		ds_idle  = 3'b001,
		ds_conn  = 3'b010,
		ds_adapt = 3'b100
	} chg_det_state_t;

	typedef struct packed {
		logic hot;
		logic warm;
		logic cool;
		logic cold;
	} chg_zone_t;

	typedef struct packed {
		logic       seen;
		logic       done;
		logic [1:0] port;
	} chg_det_t;

	typedef struct packed {
		logic           aw_full;
		logic [7:0]     aw_addr;
		logic           w_full;
		logic [31:0]    w_data;
		logic [3:0]     w_strb;
		logic           bvalid;
		logic [1:0]     bresp;
		logic           rvalid;
		logic [31:0]    rdata;
		logic [1:0]     rresp;
		logic           host_mode;
		logic           kick;
		logic           hiz_req;
		logic           ce;
		logic           te;
		logic           det_en;
		logic [1:0]     ilim;
		logic           ilim_host;
		logic [12:0]    vreg;
		logic [11:0]    ichg;
		logic [1:0]     dur;
		logic           dbl;
		logic           low_charge_bit;
		logic [2:0]     fault;
		chg_state_t     cst;
		chg_det_state_t dst;
		logic [17:0]    presc;
		logic           tick;
		logic [26:0]    safe_cnt;
		logic [14:0]    wd_cnt;
		logic           wd_run;
		logic [9:0]     conn_cnt;
		logic [14:0]    pulse_cnt;
		logic           supply_q;
		logic           gate_n;
		logic           stat_n;
		logic           chg_on;
		logic [12:0]    vreg_eff;
		logic [11:0]    ichg_eff;
		logic           lines;
	} chg_st_t;

endpackage : chg_pkg

// file: hdl/chg_ctrl.sv
// charger mode, timer, watchdog and input-limit control with an AXI4-Lite register slave
//
// How it works
// - gate low: no supply, hi-z bit, disable pin
// - default on watchdog expiry or reset bit
// - default entry reloads every configuration register
// - running charge restarts safety timer at 2 minutes
// - defaults 3.6 V or 4.2 V, 1 A
// - terminated charge stays done on default entry
// - default mode good battery forces hi-z
// - host write: host mode, clears battery hi-z
// - detection only in default, or forced
// - connection detect, adapter detect on contact or after 500 ms
// - limit 100 mA, 1.5 A for charging ports
// - detection done clears enable, releases lines
// - host limit write overrides detection result
// - source pin high 100/500 mA, low 1.5 A
// - source pin ignored in host mode
// - safety timer starts with charge, expiry suspends
// - safety fault gives 128 us pulse, status
// - fault latched; duration change restarts timer
// - double timer halves rate in slow conditions
// - 30 s watchdog, host kicks, bit self-clears
// - hot or cold zone suspends charge, timers
// - cool halves current, warm drops 140 mV
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "chg_defines.svh"

module chg_ctrl
	import chg_pkg::*;
#(
	parameter bit          DETECT_VARIANT = 1'b1,
	parameter bit          PSEL_500MA     = 1'b0,
	parameter bit          HIGH_VOLT      = 1'b0,
	parameter int unsigned TICK_CYCLES    = `CHG_TICK_NS / `CHG_CLK_NS,
	parameter int unsigned PULSE_CYCLES   = (`CHG_PULSE_NS + `CHG_CLK_NS - 1) / `CHG_CLK_NS
)(
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// axi4-lite register slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// analog monitors and pins
	input  wire logic        supply_present,
	input  wire logic        chip_disable_pin,
	input  wire logic        bat_above_good,
	input  wire logic        source_select_pin,
	input  wire chg_zone_t   thermistor_sense_input,
	input  wire logic        aux_loop_active,
	input  wire logic        term_reached,
	input  wire logic        recharge_needed,
	input  wire chg_det_t    det_result,
	// control outputs
	output logic             discharge_gate_drive_n,
	output logic             stat_int_n,
	output logic             charge_on,
	output logic [12:0]      vreg_target_mv,
	output logic [11:0]      ichg_target_ma,
	output logic [1:0]       ilim_code,
	output logic             det_lines_attached,
	output logic             host_mode
);

	chg_st_t s;
	chg_st_t next_s;

	function automatic logic [31:0] chg_merge(input logic [31:0] old_w, input logic [31:0] new_w,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_w;
		for (int i = 0; i < 4; i++)
		begin
			if (strb[i])
				r[i*8 +: 8] = new_w[i*8 +: 8];
		end
		return r;
	endfunction : chg_merge

	function automatic logic [26:0] chg_safe_limit(input logic [1:0] dur);
		int unsigned m;
		unique case (dur)
			2'h0: m = `CHG_SAFE_MIN0;
			2'h1: m = `CHG_SAFE_MIN1;
			2'h2: m = `CHG_SAFE_MIN2;
			default: m = `CHG_SAFE_MIN3;
		endcase
		// counter advances by two per millisecond at full rate
		return 27'(m * `CHG_MS_PER_MIN * 2);
	endfunction : chg_safe_limit

	////////////////////////////////////////////////////////////////////////////////
	// handshakes and outputs

	assign s_axi_awready          = !s.aw_full;
	assign s_axi_wready           = !s.w_full;
	assign s_axi_bvalid           = s.bvalid;
	assign s_axi_bresp            = s.bresp;
	assign s_axi_arready          = !s.rvalid;
	assign s_axi_rvalid           = s.rvalid;
	assign s_axi_rdata            = s.rdata;
	assign s_axi_rresp            = s.rresp;
	assign discharge_gate_drive_n = s.gate_n;
	assign stat_int_n             = s.stat_n;
	assign charge_on              = s.chg_on;
	assign vreg_target_mv         = s.vreg_eff;
	assign ichg_target_ma         = s.ichg_eff;
	assign ilim_code              = s.ilim;
	assign det_lines_attached     = s.lines;
	assign host_mode              = s.host_mode;

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		logic        wr_go;
		logic [31:0] d;
		logic [31:0] ctrl_w;
		logic        reset_wr;
		logic        ce_tog;
		logic        hiz_tog;
		logic        wd_exp;
		logic        enter_def;
		logic        tsusp;
		logic        gb_hiz;
		logic        can_chg;
		logic        half;
		logic        pulse_go;
		logic [2:0]  sfield;
		wr_go     = 1'b0;
		d         = '0;
		ctrl_w    = '0;
		reset_wr  = 1'b0;
		ce_tog    = 1'b0;
		hiz_tog   = 1'b0;
		wd_exp    = 1'b0;
		enter_def = 1'b0;
		pulse_go  = 1'b0;
		sfield    = 3'h0;
		next_s    = s;
		next_s.tick = 1'b0;
		tsusp  = thermistor_sense_input.hot | thermistor_sense_input.cold;
		gb_hiz = !s.host_mode && bat_above_good;
		half   = s.dbl && (aux_loop_active || thermistor_sense_input.warm ||
			thermistor_sense_input.cool || s.low_charge_bit);

		// millisecond enable for every slow timer
		if (s.presc == 18'(TICK_CYCLES - 1))
		begin
			next_s.presc = '0;
			next_s.tick  = 1'b1;
		end
		else
			next_s.presc = s.presc + 18'h0001;

		// write channel: address and data taken in either order
		if (s_axi_awvalid && !s.aw_full)
		begin
			next_s.aw_full = 1'b1;
			next_s.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !s.w_full)
		begin
			next_s.w_full = 1'b1;
			next_s.w_data = s_axi_wdata;
			next_s.w_strb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready)
			next_s.bvalid = 1'b0;

		ctrl_w[`CHG_CTRL_KICK]  = s.kick;
		ctrl_w[`CHG_CTRL_HIZ]   = s.hiz_req;
		ctrl_w[`CHG_CTRL_CE]    = s.ce;
		ctrl_w[`CHG_CTRL_TE]    = s.te;
		ctrl_w[`CHG_CTRL_DETEN] = s.det_en;

		wr_go = s.aw_full && s.w_full && !s.bvalid;
		if (wr_go)
		begin
			next_s.aw_full = 1'b0;
			next_s.w_full  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = `CHG_RESP_OKAY;
			unique case (s.aw_addr)
				`CHG_ADDR_CTRL:
				begin
					d = chg_merge(ctrl_w, s.w_data, s.w_strb);
					next_s.kick    = d[`CHG_CTRL_KICK];
					next_s.hiz_req = d[`CHG_CTRL_HIZ];
					next_s.ce      = d[`CHG_CTRL_CE];
					next_s.te      = d[`CHG_CTRL_TE];
					next_s.det_en  = d[`CHG_CTRL_DETEN];
					reset_wr       = d[`CHG_CTRL_RESET];
					ce_tog         = d[`CHG_CTRL_CE] != s.ce;
					hiz_tog        = d[`CHG_CTRL_HIZ] != s.hiz_req;
				end
				`CHG_ADDR_LIMIT:
				begin
					d = chg_merge({30'h0000_0000, s.ilim}, s.w_data, s.w_strb);
					next_s.ilim      = d[1:0];
					next_s.ilim_host = 1'b1;
				end
				`CHG_ADDR_CHARGE:
				begin
					d = chg_merge({4'h0, s.ichg, 3'h0, s.vreg}, s.w_data, s.w_strb);
					next_s.vreg = d[12:0];
					next_s.ichg = d[27:16];
				end
				`CHG_ADDR_SAFETY:
				begin
					d = chg_merge({28'h000_0000, s.low_charge_bit, s.dbl, s.dur}, s.w_data, s.w_strb);
					next_s.dur     = d[1:0];
					next_s.dbl     = d[2];
					next_s.low_charge_bit = d[3];
					if (s.cst == cs_run && d[1:0] != s.dur)
						next_s.safe_cnt = '0;
				end
				`CHG_ADDR_STATUS: ;
				default: next_s.bresp = `CHG_RESP_SLVERR;
			endcase
			// any completed write hands control to the host, except one that sets the reset bit
			next_s.host_mode = 1'b1;
			if (!s.wd_run)
			begin
				next_s.wd_run = 1'b1;
				next_s.wd_cnt = '0;
			end
		end

		// read channel
		if (s.rvalid && s_axi_rready)
			next_s.rvalid = 1'b0;
		else if (s_axi_arvalid && !s.rvalid)
		begin
			unique case (s.cst)
				cs_idle:  sfield = 3'h0;
				cs_run:   sfield = 3'h1;
				cs_done:  sfield = 3'h2;
				cs_fault: sfield = 3'h3;
			endcase
			next_s.rvalid = 1'b1;
			next_s.rresp  = `CHG_RESP_OKAY;
			unique case (s_axi_araddr)
				`CHG_ADDR_CTRL:   next_s.rdata = ctrl_w;
				`CHG_ADDR_LIMIT:  next_s.rdata = {30'h0000_0000, s.ilim};
				`CHG_ADDR_CHARGE: next_s.rdata = {4'h0, s.ichg, 3'h0, s.vreg};
				`CHG_ADDR_SAFETY: next_s.rdata = {28'h000_0000, s.low_charge_bit, s.dbl, s.dur};
				`CHG_ADDR_STATUS: next_s.rdata = {18'h0_0000, s.lines, s.wd_run, s.ilim,
					gb_hiz, s.host_mode, 1'b0, s.fault, 1'b0, sfield};
				default:
				begin
					next_s.rdata = '0;
					next_s.rresp = `CHG_RESP_SLVERR;
				end
			endcase
		end

		// watchdog: kick restarts the count, then the bit reads back as zero
		if (s.kick)
		begin
			next_s.kick   = 1'b0;
			next_s.wd_cnt = '0;
		end
		else if (s.wd_run && s.tick && !tsusp)
		begin
			if (s.wd_cnt == 15'(`CHG_WDOG_MS - 1))
				wd_exp = 1'b1;
			else
				next_s.wd_cnt = s.wd_cnt + 15'h0001;
		end

		// charge sequencing
		can_chg = supply_present && next_s.ce && !(next_s.hiz_req || gb_hiz || chip_disable_pin)
			&& !(wr_go && (ce_tog || hiz_tog));
		unique case (s.cst)
			cs_idle:
			begin
				if (can_chg)
				begin
					next_s.cst      = cs_run;
					next_s.safe_cnt = '0;
				end
			end
			cs_run:
			begin
				if (!can_chg)
					next_s.cst = cs_idle;
				else if (s.safe_cnt >= chg_safe_limit(s.dur))
				begin
					next_s.cst   = cs_fault;
					next_s.fault = `CHG_FAULT_SAFETY;
					pulse_go     = 1'b1;
				end
				else if (term_reached && s.te)
					next_s.cst = cs_done;
				else if (s.tick && !tsusp)
					next_s.safe_cnt = s.safe_cnt + (half ? 27'h000_0001 : 27'h000_0002);
			end
			cs_done:
			begin
				if (!can_chg)
					next_s.cst = cs_idle;
				else if (recharge_needed)
				begin
					next_s.cst      = cs_run;
					next_s.safe_cnt = '0;
				end
			end
			cs_fault:
			begin
				// stays latched until enable, hi-z or input power is cycled
				if (ce_tog || hiz_tog || (s.supply_q && !supply_present))
				begin
					next_s.cst   = cs_idle;
					next_s.fault = `CHG_FAULT_NONE;
				end
			end
		endcase

		// default mode entry
		enter_def = wd_exp || reset_wr;
		if (enter_def)
		begin
			next_s.host_mode = 1'b0;
			next_s.wd_run    = 1'b0;
			next_s.kick      = 1'b0;
			next_s.hiz_req   = 1'b0;
			next_s.ce        = 1'b1;
			next_s.te        = 1'b1;
			next_s.det_en    = 1'b0;
			next_s.ilim      = `CHG_ILIM_100;
			next_s.ilim_host = 1'b0;
			next_s.vreg      = HIGH_VOLT ? `CHG_VREG_HV_MV : `CHG_VREG_DEF_MV;
			next_s.ichg      = `CHG_ICHG_DEF_MA;
			next_s.dur       = 2'h0;
			next_s.dbl       = 1'b0;
			next_s.low_charge_bit   = 1'b0;
			// done stays done: no new cycle from the mode change alone
			if (s.cst == cs_run)
				next_s.safe_cnt = '0;
		end

		// charger-type detection on the data lines
		next_s.supply_q = supply_present;
		if (!supply_present)
			next_s.dst = ds_idle;
		else
		begin
			unique case (s.dst)
				ds_idle:
				begin
					if (DETECT_VARIANT && ((supply_present && !s.supply_q && !s.host_mode) ||
						(s.det_en && s.host_mode)))
					begin
						next_s.dst      = ds_conn;
						next_s.conn_cnt = '0;
					end
				end
				ds_conn:
				begin
					if (det_result.seen || (s.tick && s.conn_cnt == 10'(`CHG_CONN_MS - 1)))
						next_s.dst = ds_adapt;
					else if (s.tick)
						next_s.conn_cnt = s.conn_cnt + 10'h001;
				end
				ds_adapt:
				begin
					if (det_result.done)
					begin
						next_s.dst    = ds_idle;
						next_s.det_en = 1'b0;
						if (!next_s.ilim_host)
							next_s.ilim = (det_result.port == `CHG_PORT_CDP ||
								det_result.port == `CHG_PORT_DCP) ?
								`CHG_ILIM_1500 : `CHG_ILIM_100;
					end
				end
			endcase
		end
		next_s.lines = next_s.dst != ds_idle;

		// source-select pin steers the limit only outside host mode
		if (!DETECT_VARIANT && !next_s.host_mode)
			next_s.ilim = source_select_pin ? (PSEL_500MA ? `CHG_ILIM_500 : `CHG_ILIM_100)
				: `CHG_ILIM_1500;

		// fault pulse on the status pin
		if (pulse_go)
			next_s.pulse_cnt = 15'(PULSE_CYCLES);
		else if (s.pulse_cnt != '0)
			next_s.pulse_cnt = s.pulse_cnt - 15'h0001;
		next_s.stat_n = next_s.pulse_cnt == '0;

		// registered drives
		next_s.gate_n   = !(!supply_present || next_s.hiz_req || chip_disable_pin);
		next_s.chg_on   = next_s.cst == cs_run && !tsusp;
		next_s.vreg_eff = thermistor_sense_input.warm ? next_s.vreg - `CHG_WARM_DROP_MV
			: next_s.vreg;
		next_s.ichg_eff = thermistor_sense_input.cool ? {1'b0, next_s.ichg[11:1]}
			: next_s.ichg;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s          <= '0;
			s.cst      <= cs_idle;
			s.dst      <= ds_idle;
			s.ce       <= 1'b1;
			s.te       <= 1'b1;
			s.ilim     <= `CHG_ILIM_100;
			s.vreg     <= HIGH_VOLT ? `CHG_VREG_HV_MV : `CHG_VREG_DEF_MV;
			s.ichg     <= `CHG_ICHG_DEF_MA;
			s.vreg_eff <= HIGH_VOLT ? `CHG_VREG_HV_MV : `CHG_VREG_DEF_MV;
			s.ichg_eff <= `CHG_ICHG_DEF_MA;
			s.gate_n   <= 1'b1;
			s.stat_n   <= 1'b1;
		end
		else
			s <= next_s;
	end

endmodule : chg_ctrl

// file: bench/chg_ctrl_asserts.sv
// concurrent checks on the charger control block ports
`timescale 1ns/1ps
module chg_ctrl_asserts
	import chg_pkg::*;
(
	// clock and reset
	input wire logic        mclk,
	input wire logic        rst,
	// register bus
	input wire logic [7:0]  s_axi_awaddr,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// monitors and outputs
	input wire logic        supply_present,
	input wire logic        chip_disable_pin,
	input wire logic        bat_above_good,
	input wire chg_zone_t   thermistor_sense_input,
	input wire logic        discharge_gate_drive_n,
	input wire logic        charge_on,
	input wire logic        host_mode
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence bad_wr;
		wr_taken ##0 (s_axi_awaddr > 8'h10);
	endsequence
	sequence plain_wr;
		wr_taken ##0 !(s_axi_awaddr == 8'h00 && s_axi_wdata[1]);
	endsequence
	////////////////////////////////////////////////////////////////////////////////
	chk_b_after: assert property (wr_taken |=> !s_axi_awready ##1 s_axi_bvalid)
		else $error("write answer not on time");
	chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	chk_bad_resp: assert property (bad_wr |-> ##2 (s_axi_bvalid && s_axi_bresp == 2'h2))
		else $error("unmapped write not refused");
	chk_host_set: assert property (plain_wr |-> ##[1:4] host_mode)
		else $error("write did not enter host mode");
	// a few cycles of settling allowed for the registered gate driver
	chk_gate_nosup: assert property (!supply_present [*4] |-> !discharge_gate_drive_n)
		else $error("gate off without supply");
	chk_gate_cd: assert property (chip_disable_pin [*4] |-> !discharge_gate_drive_n)
		else $error("gate off while disabled");
	chk_good_hiz: assert property ((!host_mode && bat_above_good) [*4] |-> !charge_on)
		else $error("charging a good battery in default mode");
	chk_zone_stop: assert property ((thermistor_sense_input.hot || thermistor_sense_input.cold) [*4]
		|-> !charge_on)
		else $error("charging in hot or cold zone");
endmodule : chg_ctrl_asserts

// file: bench/chg_host.sv
// host model: register bus master for the charger control block
`timescale 1ns/1ps
module chg_host (
	// clock
	input wire logic        mclk,
	// write side
	output logic [7:0]      awaddr,
	output logic            awvalid,
	input wire logic        awready,
	output logic [31:0]     wdata,
	output logic [3:0]      wstrb,
	output logic            wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	output logic            bready,
	// read side
	output logic [7:0]      araddr,
	output logic            arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	output logic            rready
);
	initial
	begin
		awaddr = 8'h00;
		awvalid = 1'b0;
		wdata = 32'h0000_0000;
		wstrb = 4'hf;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 8'h00;
		arvalid = 1'b0;
		rready = 1'b0;
	end
	// the bench kicks the watchdog through this task
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		bit dn;
		begin
			n = 0;
			dn = 0;
			r = 2'h3;
			@(posedge mclk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			while (!dn && n < 200)
			begin
				@(posedge mclk);
				n++;
				if (awvalid && awready)
					awvalid <= 1'b0;
				if (wvalid && wready)
					wvalid <= 1'b0;
				if (bvalid)
				begin
					r = bresp;
					bready <= 1'b0;
					dn = 1;
				end
			end
			if (!dn)
				testbench.time_out();
		end
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		bit dn;
		begin
			n = 0;
			dn = 0;
			@(posedge mclk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			while (!dn && n < 200)
			begin
				@(posedge mclk);
				n++;
				if (arvalid && arready)
					arvalid <= 1'b0;
				if (rvalid)
				begin
					d = rdata;
					r = rresp;
					rready <= 1'b0;
					dn = 1;
				end
			end
			if (!dn)
				testbench.time_out();
		end
	endtask : rd
endmodule : chg_host

// file: bench/testbench.sv
// self-checking bench for the charger control block
`timescale 1ns/1ps
module testbench;
	import chg_pkg::*;
	typedef struct packed {
		logic        sup;
		logic        cd;
		logic        bat;
		chg_zone_t   zn;
		logic        gate_n;
		logic        chg;
		logic [12:0] v;
		logic [11:0] i;
	} chg_row_t;
	// default mode, no host write yet: {supply, disable, good bat, zone} -> outputs
	localparam chg_row_t ROWS [8] = '{
		'{1'b1, 1'b0, 1'b0, 4'h0, 1'b1, 1'b1, 13'h0e10, 12'h03e8},
		'{1'b0, 1'b0, 1'b0, 4'h0, 1'b0, 1'b0, 13'h0e10, 12'h03e8},
		'{1'b1, 1'b1, 1'b0, 4'h0, 1'b0, 1'b0, 13'h0e10, 12'h03e8},
		'{1'b1, 1'b0, 1'b0, 4'h8, 1'b1, 1'b0, 13'h0e10, 12'h03e8},
		'{1'b1, 1'b0, 1'b0, 4'h1, 1'b1, 1'b0, 13'h0e10, 12'h03e8},
		'{1'b1, 1'b0, 1'b0, 4'h4, 1'b1, 1'b1, 13'h0d84, 12'h03e8},
		'{1'b1, 1'b0, 1'b0, 4'h2, 1'b1, 1'b1, 13'h0e10, 12'h01f4},
		'{1'b1, 1'b0, 1'b1, 4'h0, 1'b1, 1'b0, 13'h0e10, 12'h03e8}};
	logic mclk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, supply_present, chip_disable_pin;
	logic bat_above_good, gate_n, stat_n, charge_on, lines, host_mode, term, rech;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd_d;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs, ilim_code;
	logic [12:0] vreg;
	logic [11:0] ichg;
	chg_zone_t zone;
	chg_det_t det;
	int fail_count, compares, n;
	////////////////////////////////////////////////////////////////////////////////
	chg_ctrl #(.TICK_CYCLES(2), .PULSE_CYCLES(8)) chg_ctrl_inst (.mclk(mclk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.supply_present(supply_present), .chip_disable_pin(chip_disable_pin),
		.bat_above_good(bat_above_good), .source_select_pin(1'b0),
		.thermistor_sense_input(zone), .aux_loop_active(1'b0), .term_reached(term),
		.recharge_needed(rech), .det_result(det), .discharge_gate_drive_n(gate_n),
		.stat_int_n(stat_n), .charge_on(charge_on), .vreg_target_mv(vreg),
		.ichg_target_ma(ichg), .ilim_code(ilim_code), .det_lines_attached(lines),
		.host_mode(host_mode));
	chg_host chg_host_inst (.mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		begin
			compares++;
			if (seen !== exp)
			begin
				fail_count++;
				$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask : chk
	task automatic w(input logic [7:0] a, input logic [31:0] d);
		begin
			chg_host_inst.wr(a, d, rs);
			chk(rs, 2'h0);
			repeat (3) @(posedge mclk);
		end
	endtask : w
	task end_of_test();
		begin
			if (fail_count == 0 && compares > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask : end_of_test
	task time_out();
		begin
			fail_count++;
			end_of_test();
		end
	endtask : time_out
	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial
	begin
		rst = 1'b1;
		supply_present = 1'b0;
		chip_disable_pin = 1'b0;
		bat_above_good = 1'b0;
		term = 1'b0;
		rech = 1'b0;
		zone = 4'h0;
		det = '{seen: 1'b0, done: 1'b1, port: 2'h2};
		fail_count = 0;
		compares = 0;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		repeat (3) @(posedge mclk);
		chk({host_mode, ilim_code, stat_n, vreg, ichg}, {1'b0, 2'h0, 1'b1, 13'h0e10, 12'h03e8});
		supply_present <= 1'b1;
		repeat (10) @(posedge mclk);
		chk(lines, 1'b1);
		repeat (960) @(posedge mclk);
		chk(ilim_code, 2'h0);
		for (n = 0; n < 80 && ilim_code !== 2'h2; n++)
			@(posedge mclk);
		chk(ilim_code, 2'h2);
		if (ilim_code !== 2'h2)
			time_out();
		chk(lines, 1'b0);
		for (int k = 0; k < 8; k++)
		begin
			supply_present <= ROWS[k].sup;
			chip_disable_pin <= ROWS[k].cd;
			bat_above_good <= ROWS[k].bat;
			zone <= ROWS[k].zn;
			repeat (6) @(posedge mclk);
			chk(gate_n, ROWS[k].gate_n);
			chk(charge_on, ROWS[k].chg);
			if (ROWS[k].chg)
				chk({vreg, ichg}, {ROWS[k].v, ROWS[k].i});
		end
		w(8'h04, 32'h0000_0000);
		chk({host_mode, charge_on}, 2'h3);
		chg_host_inst.rd(8'h00, rd_d, rs);
		chk(rd_d, 32'h0000_0018);
		bat_above_good <= 1'b0;
		repeat (1100) @(posedge mclk);
		chk(ilim_code, 2'h0);
		w(8'h00, 32'h0000_001c);
		chk(gate_n, 1'b0);
		w(8'h00, 32'h0000_0019);
		chg_host_inst.rd(8'h00, rd_d, rs);
		chk(rd_d, 32'h0000_0018);
		chg_host_inst.wr(8'h40, 32'h0000_0001, rs);
		chk(rs, 2'h2);
		chg_host_inst.rd(8'h40, rd_d, rs);
		chk({rd_d, rs}, {32'h0000_0000, 2'h2});
		w(8'h08, 32'h07d0_0fa0);
		chk({vreg, ichg}, {13'h0fa0, 12'h07d0});
		term <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(charge_on, 1'b0);
		// reset bit with termination cleared: reload must bring it back
		w(8'h00, 32'h0000_000a);
		chk({host_mode, vreg, ichg}, {1'b0, 13'h0e10, 12'h03e8});
		chk(charge_on, 1'b0);
		chg_host_inst.rd(8'h00, rd_d, rs);
		chk(rd_d, 32'h0000_0018);
		term <= 1'b0;
		rech <= 1'b1;
		repeat (3) @(posedge mclk);
		chk(charge_on, 1'b1);
		rech <= 1'b0;
		// host-forced detection, connection seen at once, charging port found
		det <= '{seen: 1'b1, done: 1'b1, port: 2'h1};
		w(8'h00, 32'h0000_0038);
		chg_host_inst.rd(8'h00, rd_d, rs);
		chk(rd_d, 32'h0000_0018);
		chk({lines, ilim_code}, 3'h2);
		w(8'h08, 32'h07d0_0fa0);
		w(8'h00, 32'h0000_0019);
		repeat (58000) @(posedge mclk);
		chk(host_mode, 1'b1);
		for (n = 0; n < 4000 && host_mode !== 1'b0; n++)
			@(posedge mclk);
		if (host_mode !== 1'b0)
			time_out();
		repeat (3) @(posedge mclk);
		chk({host_mode, vreg, ichg}, {1'b0, 13'h0e10, 12'h03e8});
		end_of_test();
	end
endmodule : testbench

bind chg_ctrl chg_ctrl_asserts chg_ctrl_asserts_inst (.mclk(mclk), .rst(rst),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.supply_present(supply_present), .chip_disable_pin(chip_disable_pin),
	.bat_above_good(bat_above_good), .thermistor_sense_input(thermistor_sense_input),
	.discharge_gate_drive_n(discharge_gate_drive_n), .charge_on(charge_on),
	.host_mode(host_mode));
